// file: core/lsb_alu.v
// Behaviour
// (RULE1) AND destination with register or immediate, byte/word/long, write back.
// (RULE2) OR destination with register or immediate, byte/word/long, write back.
// (RULE3) XOR destination with register or immediate, byte/word/long, write back.
// (RULE4) Invert every bit of destination at the selected size.
// (RULE5) Arithmetic shift by one or two, sign kept on right shifts.
// (RULE6) Logical shift by one or two, zeros fill vacated bits.
// (RULE7) Rotate by one or two, bits wrap to the other end.
// (RULE8) Rotate by one or two through the carry flag.
// (RULE9) Bit index from 3-bit immediate or low three register bits.
// (RULE10) Set the selected byte bit to one and write back.
// (RULE11) Clear the selected byte bit to zero and write back.
// (RULE12) Invert the selected byte bit and write back.
// (RULE13) Bit test loads zero flag with inverse of bit, operand unchanged.
// (RULE14) Carry becomes carry AND selected bit.
// (RULE15) Carry becomes carry OR selected bit.
// (RULE16) Carry becomes carry XOR selected bit.
// (RULE17) Inverted forms use complemented bit and immediate index only.
// (RULE18) Copy selected bit into carry, operand unchanged.
// (RULE19) Copy complement of selected bit into carry, immediate index.
// (RULE20) Store carry into selected bit, other bits kept.
// (RULE21) Store inverted carry into selected bit, immediate index.
// (RULE22) Shifts and rotates load carry with last bit out; set N and Z.
// (RULE23) Logic operations set N from msb, Z on zero, clear V.
`timescale 1ns/1ps
`default_nettype none
`include "lsb_alu_regs.vh"

module lsb_alu (
    input wire clock,
    input wire reset_n,
    input wire start,
    input wire [4:0] op,
    input wire [1:0] size,
    input wire use_imm,
    input wire [31:0] dest_value,
    input wire [31:0] source_register,
    input wire [31:0] imm_value,
    input wire shift_two,
    input wire bit_index_from_reg,
    input wire [2:0] bit_imm,
    input wire invert_bit,
    output reg done,
    output reg write_back,
    output reg [31:0] result,
    output reg flag_c,
    output reg flag_z,
    output reg flag_n,
    output reg flag_v
);

    reg [31:0] next_result;
    reg next_wb;
    reg next_c;
    reg next_z;
    reg next_n;
    reg next_v;
    reg [31:0] mask;
    reg [31:0] sign_mask;
    reg [31:0] opnd;
    reg [31:0] r1;
    reg [31:0] r2;
    reg c1;
    reg c2;
    reg msb;
    reg lsb;
    reg [2:0] idx;
    reg sel_bit;
    reg nz_upd;
    reg is_shift;
    reg right;

    // One combinational pass works out result, flags and write-back together.
    always @* begin
        mask = 32'hffffffff;
        sign_mask = 32'h80000000;
        case (size)
            `LSB_SIZE_BYTE: begin
                mask = 32'h000000ff;
                sign_mask = 32'h00000080;
            end
            `LSB_SIZE_WORD: begin
                mask = 32'h0000ffff;
                sign_mask = 32'h00008000;
            end
            default: begin
                mask = 32'hffffffff;
                sign_mask = 32'h80000000;
            end
        endcase
        opnd = use_imm ? imm_value : source_register;
        // (RULE9) Bit index select.
        // (RULE17) Inverted forms ignore a register index.
        idx = (bit_index_from_reg && !invert_bit) ? source_register[2:0] : bit_imm;
        sel_bit = dest_value[idx];
        // (RULE17) Complemented bit for inverted forms.
        if (invert_bit) begin
            sel_bit = ~sel_bit;
        end
        next_result = dest_value;
        next_wb = 1'b0;
        next_c = flag_c;
        next_z = flag_z;
        next_n = flag_n;
        next_v = flag_v;
        nz_upd = 1'b0;
        is_shift = 1'b0;
        right = op[0];
        r1 = dest_value & mask;
        r2 = r1;
        c1 = flag_c;
        c2 = flag_c;
        msb = 1'b0;
        lsb = 1'b0;
        case (op)
            // (RULE1) Logical AND.
            `LSB_OP_AND: begin
                next_result = dest_value & opnd;
                nz_upd = 1'b1;
            end
            // (RULE2) Logical OR.
            `LSB_OP_OR: begin
                next_result = dest_value | opnd;
                nz_upd = 1'b1;
            end
            // (RULE3) Logical XOR.
            `LSB_OP_XOR: begin
                next_result = dest_value ^ opnd;
                nz_upd = 1'b1;
            end
            // (RULE4) One's complement.
            `LSB_OP_NOT: begin
                next_result = ~dest_value;
                nz_upd = 1'b1;
            end
            `LSB_OP_ARITH_SHIFT_LEFT, `LSB_OP_ARITH_SHIFT_RIGHT,
            `LSB_OP_LOGICAL_SHIFT_LEFT, `LSB_OP_LOGICAL_SHIFT_RIGHT,
            `LSB_OP_ROTATE_LEFT, `LSB_OP_ROTATE_RIGHT,
            `LSB_OP_ROTATE_LEFT_THROUGH_CARRY, `LSB_OP_ROTATE_RIGHT_THROUGH_CARRY: begin
                is_shift = 1'b1;
            end
            // (RULE10) Set bit.
            `LSB_OP_SET_SELECTED_BIT: begin
                next_result[idx] = 1'b1;
                next_wb = 1'b1;
            end
            // (RULE11) Clear bit.
            `LSB_OP_CLEAR_SELECTED_BIT: begin
                next_result[idx] = 1'b0;
                next_wb = 1'b1;
            end
            // (RULE12) Invert bit.
            `LSB_OP_BINV: begin
                next_result[idx] = ~dest_value[idx];
                next_wb = 1'b1;
            end
            // (RULE13) Zero flag from inverse.
            `LSB_OP_BTEST: begin
                next_z = ~dest_value[idx];
            end
            // (RULE14) Carry AND.
            `LSB_OP_CAND: begin
                next_c = flag_c & sel_bit;
            end
            // (RULE15) Carry OR.
            `LSB_OP_COR: begin
                next_c = flag_c | sel_bit;
            end
            // (RULE16) Carry XOR.
            `LSB_OP_CXOR: begin
                next_c = flag_c ^ sel_bit;
            end
            // (RULE18) (RULE19) Bit to carry.
            `LSB_OP_CLOAD: begin
                next_c = sel_bit;
            end
            // (RULE20) (RULE21) Carry to bit.
            `LSB_OP_CSTORE: begin
                next_result[idx] = invert_bit ? ~flag_c : flag_c;
                next_wb = 1'b1;
            end
            default: begin
                next_result = dest_value;
            end
        endcase
        if (is_shift) begin
            msb = r1[31];
            case (size)
                `LSB_SIZE_BYTE: begin
                    msb = r1[7];
                end
                `LSB_SIZE_WORD: begin
                    msb = r1[15];
                end
                default: begin
                    msb = r1[31];
                end
            endcase
            lsb = r1[0];
            if (!right) begin
                c1 = msb;
                // (RULE6) (RULE7) (RULE8) Left fill bit.
                case (op)
                    // Rotate feeds the msb back in, through-carry the old carry.
                    `LSB_OP_ROTATE_LEFT: begin
                        r1 = ((r1 << 1) | {31'h0, msb}) & mask;
                    end
                    `LSB_OP_ROTATE_LEFT_THROUGH_CARRY: begin
                        r1 = ((r1 << 1) | {31'h0, flag_c}) & mask;
                    end
                    default: begin
                        r1 = (r1 << 1) & mask;
                    end
                endcase
            end else begin
                c1 = lsb;
                r1 = r1 >> 1;
                // (RULE5) Sign kept on arithmetic right.
                case (op)
                    `LSB_OP_ARITH_SHIFT_RIGHT: begin
                        r1 = r1 | (msb ? sign_mask : 32'h0);
                    end
                    `LSB_OP_ROTATE_RIGHT: begin
                        r1 = r1 | (lsb ? sign_mask : 32'h0);
                    end
                    `LSB_OP_ROTATE_RIGHT_THROUGH_CARRY: begin
                        r1 = r1 | (flag_c ? sign_mask : 32'h0);
                    end
                    default: begin
                        r1 = r1;
                    end
                endcase
            end
            r2 = r1;
            c2 = c1;
            if (shift_two) begin
                // The second step works on the first step's result and carry.
                case (size)
                    `LSB_SIZE_BYTE: begin
                        msb = r1[7];
                    end
                    `LSB_SIZE_WORD: begin
                        msb = r1[15];
                    end
                    default: begin
                        msb = r1[31];
                    end
                endcase
                lsb = r1[0];
                if (!right) begin
                    c2 = msb;
                    case (op)
                        `LSB_OP_ROTATE_LEFT: begin
                            r2 = ((r1 << 1) | {31'h0, msb}) & mask;
                        end
                        `LSB_OP_ROTATE_LEFT_THROUGH_CARRY: begin
                            r2 = ((r1 << 1) | {31'h0, c1}) & mask;
                        end
                        default: begin
                            r2 = (r1 << 1) & mask;
                        end
                    endcase
                end else begin
                    c2 = lsb;
                    r2 = r1 >> 1;
                    case (op)
                        `LSB_OP_ARITH_SHIFT_RIGHT: begin
                            r2 = r2 | (msb ? sign_mask : 32'h0);
                        end
                        `LSB_OP_ROTATE_RIGHT: begin
                            r2 = r2 | (lsb ? sign_mask : 32'h0);
                        end
                        `LSB_OP_ROTATE_RIGHT_THROUGH_CARRY: begin
                            r2 = r2 | (c1 ? sign_mask : 32'h0);
                        end
                        default: begin
                            r2 = r2;
                        end
                    endcase
                end
            end
            next_result = (dest_value & ~mask) | r2;
            // (RULE22) Carry is last bit out.
            next_c = c2;
            nz_upd = 1'b1;
        end
        if (nz_upd) begin
            next_wb = 1'b1;
            // (RULE23) N, Z from sized result; V cleared by logic only.
            next_z = ((next_result & mask) == 32'h0);
            case (size)
                `LSB_SIZE_BYTE: begin
                    next_n = next_result[7];
                end
                `LSB_SIZE_WORD: begin
                    next_n = next_result[15];
                end
                default: begin
                    next_n = next_result[31];
                end
            endcase
            // Shifts and rotates leave the overflow flag as it was.
            if (!is_shift) begin
                next_v = 1'b0;
            end
            next_result = (dest_value & ~mask) | (next_result & mask);
        end
        // Bit operations always act on a byte operand.
        if (!nz_upd && !is_shift) begin
            next_result = {dest_value[31:8], next_result[7:0]};
        end
    end

    always @(posedge clock) begin
        if (!reset_n) begin
            done <= `LSB_PULSE_RESET;
            write_back <= `LSB_PULSE_RESET;
            result <= `LSB_RESULT_RESET;
        end else begin
            done <= start;
            write_back <= start & next_wb;
            if (start) begin
                result <= next_result;
            end
        end
    end

    // Flags only move on an accepted operation, so the next one reads them.
    always @(posedge clock) begin
        if (!reset_n) begin
            flag_c <= `LSB_FLAG_RESET;
            flag_z <= `LSB_FLAG_RESET;
            flag_n <= `LSB_FLAG_RESET;
            flag_v <= `LSB_FLAG_RESET;
        end else if (start) begin
            flag_c <= next_c;
            flag_z <= next_z;
            flag_n <= next_n;
            flag_v <= next_v;
        end
    end

endmodule // lsb_alu
`default_nettype wire

// file: core/lsb_alu_regs.vh
`ifndef LSB_ALU_REGS_VH
`define LSB_ALU_REGS_VH
// Operation codes.
`define LSB_OP_AND 5'h00
`define LSB_OP_OR 5'h01
`define LSB_OP_XOR 5'h02
`define LSB_OP_NOT 5'h03
`define LSB_OP_ARITH_SHIFT_LEFT 5'h04
`define LSB_OP_ARITH_SHIFT_RIGHT 5'h05
`define LSB_OP_LOGICAL_SHIFT_LEFT 5'h06
`define LSB_OP_LOGICAL_SHIFT_RIGHT 5'h07
`define LSB_OP_ROTATE_LEFT 5'h08
`define LSB_OP_ROTATE_RIGHT 5'h09
`define LSB_OP_ROTATE_LEFT_THROUGH_CARRY 5'h0a
`define LSB_OP_ROTATE_RIGHT_THROUGH_CARRY 5'h0b
`define LSB_OP_SET_SELECTED_BIT 5'h0c
`define LSB_OP_CLEAR_SELECTED_BIT 5'h0d
`define LSB_OP_BINV 5'h0e
`define LSB_OP_BTEST 5'h0f
`define LSB_OP_CAND 5'h10
`define LSB_OP_COR 5'h11
`define LSB_OP_CXOR 5'h12
`define LSB_OP_CLOAD 5'h13
`define LSB_OP_CSTORE 5'h14
// Operand sizes.
`define LSB_SIZE_BYTE 2'h0
`define LSB_SIZE_WORD 2'h1
`define LSB_SIZE_LONG 2'h2
// Flag reset values.
`define LSB_FLAG_RESET 1'h0
// Output reset values.
`define LSB_PULSE_RESET 1'h0
`define LSB_RESULT_RESET 32'h00000000
`endif

// file: verif/lsb_alu_checker.sv
`timescale 1ns/1ps
`default_nettype none
module lsb_alu_checker (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic start,
    input wire logic [4:0] op,
    input wire logic [1:0] size,
    input wire logic use_imm,
    input wire logic [31:0] dest_value,
    input wire logic [31:0] source_register,
    input wire logic [31:0] imm_value,
    input wire logic bit_index_from_reg,
    input wire logic [2:0] bit_imm,
    input wire logic invert_bit,
    input wire logic done,
    input wire logic write_back,
    input wire logic [31:0] result,
    input wire logic flag_c,
    input wire logic flag_z
);
    logic [31:0] pd, px;
    logic [2:0] pi;
    always @(posedge clock) begin
        pd <= dest_value;
        px <= use_imm ? imm_value : source_register;
        pi <= (bit_index_from_reg && !invert_bit) ? source_register[2:0] : bit_imm;
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    a_done_follows:
        assert property (start |=> done) else $error("no done after start");
    a_no_stray_done:
        assert property (!start |=> !done) else $error("done without start");
    a_and_long:
        assert property (start && op == 5'h00 && size == 2'h2
            |=> write_back && result == (pd & px))
            else $error("and result");
    a_or_long:
        assert property (start && op == 5'h01 && size == 2'h2 |=> result == (pd | px))
            else $error("or result");
    a_xor_long:
        assert property (start && op == 5'h02 && size == 2'h2 |=> result == (pd ^ px))
            else $error("xor result");
    a_not_long:
        assert property (start && op == 5'h03 && size == 2'h2 |=> result == ~pd)
            else $error("not result");
    a_set_bit:
        assert property (start && op == 5'h0c |=> result[7:0] == (pd[7:0] | (8'h01 << pi)))
            else $error("set bit");
    a_clear_bit:
        assert property (start && op == 5'h0d |=> result[7:0] == (pd[7:0] & ~(8'h01 << pi)))
            else $error("clear bit");
    a_test_zero:
        assert property (start && op == 5'h0f |=> flag_z == !pd[pi] && !write_back)
            else $error("bit test");
    a_load_carry:
        assert property (start && op == 5'h13 && !invert_bit |=> flag_c == pd[pi])
            else $error("bit load");
    cover property (start && op == 5'h0b);
    cover property (start ##1 start);
    cover property (start && op == 5'h14 && invert_bit);
endmodule // lsb_alu_checker

bind lsb_alu lsb_alu_checker chk (.clock(clock), .reset_n(reset_n), .start(start), .op(op),
    .size(size), .use_imm(use_imm), .dest_value(dest_value), .imm_value(imm_value),
    .source_register(source_register), .bit_index_from_reg(bit_index_from_reg),
    .bit_imm(bit_imm), .invert_bit(invert_bit), .done(done), .write_back(write_back),
    .result(result), .flag_c(flag_c), .flag_z(flag_z));
`default_nettype wire

// file: verif/test_lsb_alu.sv
`timescale 1ns/1ps
`default_nettype none
module test_logic_shift_bit_manip_alu;
    logic clock = 0, reset_n = 0, start = 0, use_imm = 0, shift_two = 0;
    logic bit_index_from_reg = 0, invert_bit = 0, mc = 0, mz = 0, mn = 0, mv = 0;
    logic [4:0] op = 0;
    logic [1:0] size = 0;
    logic [2:0] bit_imm = 0;
    logic [31:0] dest_value = 0, source_register = 0, imm_value = 0;
    wire done, write_back, flag_c, flag_z, flag_n, flag_v;
    wire [31:0] result;
    logic [36:0] q[$];
    logic [36:0] e;
    int fail_count = 0, tests_run = 0;
    lsb_alu uut (.clock(clock), .reset_n(reset_n), .start(start), .op(op), .size(size),
        .use_imm(use_imm), .dest_value(dest_value), .source_register(source_register),
        .imm_value(imm_value), .shift_two(shift_two), .bit_index_from_reg(bit_index_from_reg),
        .bit_imm(bit_imm), .invert_bit(invert_bit), .done(done), .write_back(write_back),
        .result(result), .flag_c(flag_c), .flag_z(flag_z), .flag_n(flag_n), .flag_v(flag_v));
    initial forever #4 clock = ~clock;
    task automatic fault(input string msg);
        $display("wrong value at %0t: %s", $time, msg);
        fail_count++;
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Drives one operation at the falling edge and notes what must come back.
    task automatic issue(input logic [4:0] o, input logic [1:0] s);
        logic [31:0] m, r, x;
        logic [2:0] ix;
        logic b, msb, lsb;
        int w;
        @(negedge clock);
        start = 1'b1;
        op = o;
        size = s;
        dest_value = $urandom;
        source_register = $urandom;
        imm_value = $urandom;
        use_imm = 1'($urandom);
        shift_two = 1'($urandom);
        bit_imm = 3'($urandom);
        invert_bit = (o > 5'h0f) ? 1'($urandom) : 1'b0;
        // Inverted forms must ignore a register index even when one is offered.
        bit_index_from_reg = 1'($urandom);
        w = 8 << s;
        m = (s == 2'h2) ? 32'hffffffff : (32'h1 << w) - 1;
        r = dest_value & m;
        x = use_imm ? imm_value : source_register;
        ix = (bit_index_from_reg && !invert_bit) ? source_register[2:0] : bit_imm;
        b = dest_value[ix] ^ invert_bit;
        case (o)
            5'h00: r = r & x;
            5'h01: r = r | x;
            5'h02: r = r ^ x;
            5'h03: r = ~r;
            5'h0c: r[ix] = 1'b1;
            5'h0d: r[ix] = 1'b0;
            5'h0e: r[ix] = ~r[ix];
            5'h0f: mz = ~b;
            5'h10: mc = mc & b;
            5'h11: mc = mc | b;
            5'h12: mc = mc ^ b;
            5'h13: mc = b;
            5'h14: r[ix] = mc ^ invert_bit;
            default: ;
        endcase
        if (o >= 5'h04 && o <= 5'h0b)
            for (int k = 0; k <= int'(shift_two); k++) begin
                msb = r[w - 1];
                lsb = r[0];
                r = o[0] ? r >> 1 : r << 1;
                if (o == 5'h05) r[w - 1] = msb;
                if (o == 5'h08) r[0] = msb;
                if (o == 5'h09) r[w - 1] = lsb;
                if (o == 5'h0a) r[0] = mc;
                if (o == 5'h0b) r[w - 1] = mc;
                mc = o[0] ? lsb : msb;
                r = r & m;
            end
        r = r & m;
        if (o < 5'h0c) begin
            mn = r[w - 1];
            mz = (r == 32'h0);
            if (o < 5'h04) mv = 1'b0;
        end
        q.push_back({o < 5'h0f || o == 5'h14, mc, mz, mn, mv, (dest_value & ~m) | r});
    endtask
    task automatic idle();
        @(negedge clock);
        start = 0;
    endtask
    task automatic check_reset();
        tests_run++;
        if ({done, write_back, result, flag_c, flag_z, flag_n, flag_v} !== 38'h0) fault("reset");
    endtask
    always @(posedge clock) begin
        #1;
        if (reset_n && done === 1'b1) begin
            if (q.size() == 0) fault("done with nothing pending");
            else begin
                e = q.pop_front();
                tests_run++;
                if (result !== e[31:0]) fault("result");
                if ({write_back, flag_c, flag_z, flag_n, flag_v} !== e[36:32]) fault("flags");
            end
        end
    end
    initial begin
        void'($urandom(52054));
        repeat (5) @(negedge clock);
        reset_n = 1;
        check_reset();
        for (int n = 0; n < 6; n++)
            for (int o = 0; o < 22; o++)
                for (int s = 0; s < 3; s++) begin
                    issue(5'(o), 2'(s));
                    if (n % 2) idle();
                end
        issue(5'h1f, 2'h0);
        idle();
        reset_n = 0;
        {mc, mz, mn, mv} = 4'h0;
        repeat (2) @(negedge clock);
        check_reset();
        reset_n = 1;
        for (int o = 16; o < 21; o++) issue(5'(o), 2'h0);
        idle();
        for (int i = 0; i < 10 && q.size() > 0; i++) @(negedge clock);
        if (q.size() > 0) fault("missing done");
        conclude();
    end
endmodule // test_logic_shift_bit_manip_alu
`default_nettype wire
